// ---- pkg/irq_ctrl_pkg.sv ----
// Constants for the vectored interrupt request controller.
// Assumes a byte-wide register port and a core that acknowledges vectors.
package irq_ctrl_pkg;
  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int NUM_VEC = 20;
  localparam int NUM_PORT_SRC = 12;
  localparam int NUM_PERI_SRC = 8;
  localparam int NUM_EDGE_SEL = 8;
  localparam int VEC_W = 5;
  localparam int ADDR_W = 12;
  // Vector order: 0..7 peripheral group, 8..15 port A pins 7..0, 16..19 port C 3..0
  localparam logic [VEC_W-1:0] VEC_PORTA_BASE = 5'h08;
  localparam logic [VEC_W-1:0] VEC_PORTC_BASE = 5'h10;
  // Peripheral vector slots
  // The converter owns bit 0, so the watchdog takes the free top slot
  localparam int PV_WDT = 7;
  localparam int PV_URX = 4;
  localparam int PV_UTX = 3;
  localparam int PV_CONV = 0;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_PERI_REQ = 12'h0FC0;
  localparam logic [ADDR_W-1:0] ADDR_PORTA_REQ = 12'h0FC3;
  localparam logic [ADDR_W-1:0] ADDR_PORTC_REQ = 12'h0FC6;
  localparam logic [ADDR_W-1:0] ADDR_PORTC_ENH = 12'h0FC7;
  localparam logic [ADDR_W-1:0] ADDR_PORTC_ENL = 12'h0FC8;
  localparam logic [ADDR_W-1:0] ADDR_PORTA_ENH = 12'h0FC4;
  localparam logic [ADDR_W-1:0] ADDR_PORTA_ENL = 12'h0FC5;
  localparam logic [ADDR_W-1:0] ADDR_PERI_ENH = 12'h0FC1;
  localparam logic [ADDR_W-1:0] ADDR_PERI_ENL = 12'h0FC2;
  localparam logic [ADDR_W-1:0] ADDR_EDGE_SEL = 12'h0FCD;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h0FCF;
  localparam logic [ADDR_W-1:0] ADDR_VEC_ADDR = 12'h0FCE;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Writable bits of the peripheral request register (reserved 2:1 read zero)
  localparam logic [7:0] PERI_WR_MASK = 8'hF9;
  localparam logic [7:0] PORTC_MASK = 8'h0F;
  localparam int CTRL_GIE = 7;
  // Vector table base address in program memory, two bytes per vector
  localparam logic [15:0] VEC_TABLE_BASE = 16'h0008;
  localparam logic [1:0] PRIO_OFF = 2'h0;
  localparam logic [1:0] PRIO_HIGH = 2'h3;
endpackage

// ---- src/vectored_irq_ctrl.sv ----
// Vectored interrupt request controller: pending flags, priority, core handoff.
// Assumes sources give one-cycle same-clock requests except pins, which are async.
//
// Contract
// - There are twenty vectors, twelve fed by port pins and eight by peripherals.
// - Eight port pins trigger on a selectable edge, four trigger on both edges.
// - Each source has its own priority from three levels plus disabled.
// - A watchdog time-out raises a request when the reset-select option is 0.
// - A vector is fetched as high byte at an even address then low byte at the odd one.
// - A request sets its pending bit to 1 in vectored and polled handling alike.
// - With interrupts enabled, pending enabled requests are forwarded to the core.
// - With interrupts disabled the core is not interrupted and flags stay readable.
// - Port register bit 7 is pin 7, bit 6 pin 6 or comparator, bits 5..0 pins 5..0.
// - Peripheral register bit 4 is receive, bit 3 transmit, bit 0 converter.
// - The converter and some port sources can be left out per variant.
// - After service the core resumes the work it was doing.
// - A high and low enable bit per source encode disabled, low, nominal, high.
`timescale 1ns/1ps
module vectored_irq_ctrl
  import irq_ctrl_pkg::*;
#(
  parameter bit HAS_CONVERTER = 1'b1,
  parameter logic [7:0] PORTA_PRESENT = 8'hFF,
  parameter logic [3:0] PORTC_PRESENT = 4'hF
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Request sources
  input wire logic [7:0] port_a_pin,
  input wire logic [3:0] port_c_pin,
  input wire logic comparator_request,
  input wire logic [NUM_PERI_SRC-1:0] peri_request,
  input wire logic watchdog_timeout,
  input wire logic watchdog_reset_select_option,
  // Core handoff
  output logic irq_to_core,
  output logic [VEC_W-1:0] irq_vector,
  output logic [15:0] vec_fetch_addr,
  input wire logic irq_ack,
  output logic watchdog_sys_reset
);
  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_s1_reg, rst_n;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end

  // ----------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------
  // Three stages; the first is read only by the second
  logic [11:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_st_reg;
  logic [11:0] pin_s1_next, pin_s2_next, pin_s3_next, pin_st_next;
  logic [11:0] pin_event;
  logic [7:0] edge_sel_reg, edge_sel_next;
  logic [3:0] settle_reg, settle_next;
  always_comb begin
    pin_s1_next = {port_c_pin, port_a_pin};
    pin_s2_next = pin_s1_reg;
    pin_s3_next = pin_s2_reg;
    pin_st_next = pin_st_reg;
    pin_event = '0;
    for (int i = 0; i < NUM_PORT_SRC; i++) begin
      // A change counts once the second and third stages agree
      if (pin_s2_reg[i] == pin_s3_reg[i] && pin_s3_reg[i] != pin_st_reg[i]) begin
        pin_st_next[i] = pin_s3_reg[i];
        if (i < NUM_EDGE_SEL) begin
          pin_event[i] = edge_sel_reg[i] ? !pin_s3_reg[i] : pin_s3_reg[i];
        end else begin
          pin_event[i] = 1'b1;
        end
      end
    end
    // Until the chain holds real pin levels, adopt them quietly: a pin that
    // idles high must not look like a rising edge after reset
    settle_next = (settle_reg << 1) | 4'h1;
    if (!(&settle_reg)) begin
      pin_st_next = pin_s3_reg;
      pin_event = '0;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      pin_s3_reg <= '0;
      pin_st_reg <= '0;
      settle_reg <= 4'h0;
    end else begin
      pin_s1_reg <= pin_s1_next;
      pin_s2_reg <= pin_s2_next;
      pin_s3_reg <= pin_s3_next;
      pin_st_reg <= pin_st_next;
      settle_reg <= settle_next;
    end
  end

  // ----------------------------------------
  // Registers and pending flags
  // ----------------------------------------
  logic [7:0] porta_req_reg, porta_req_next, peri_req_reg, peri_req_next;
  logic [3:0] portc_req_reg, portc_req_next;
  logic [7:0] porta_enh_reg, porta_enh_next, porta_enl_reg, porta_enl_next;
  logic [7:0] peri_enh_reg, peri_enh_next, peri_enl_reg, peri_enl_next;
  logic [3:0] portc_enh_reg, portc_enh_next, portc_enl_reg, portc_enl_next;
  logic gie_reg, gie_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [7:0] porta_set, peri_set;
  logic [3:0] portc_set;
  logic [NUM_VEC-1:0] ack_clr;
  logic [VEC_W-1:0] vec_reg, vec_next;
  logic irq_reg, irq_next, wdt_rst_reg, wdt_rst_next;
  logic [15:0] fetch_reg, fetch_next;

  always_comb begin
    // Pin 6 shares its flag with the comparator
    porta_set = pin_event[7:0] | {1'b0, comparator_request, 6'h00};
    porta_set = porta_set & PORTA_PRESENT;
    portc_set = pin_event[11:8] & PORTC_PRESENT;
    peri_set = peri_request;
    peri_set[PV_WDT] = watchdog_timeout & !watchdog_reset_select_option;
    if (!HAS_CONVERTER) begin
      peri_set[PV_CONV] = 1'b0;
    end
    peri_set = peri_set & PERI_WR_MASK;
    ack_clr = '0;
    if (irq_ack && irq_reg) begin
      ack_clr[vec_reg] = 1'b1;
    end
  end

  // Bit b of a group sits at base + (7 - b) so bit 7 comes first; port C passes base 12, so its bit 3 lands on vector 16
  function automatic logic [7:0] ack_bits(input logic [NUM_VEC-1:0] a, input int base);
    logic [7:0] r;
    r = '0;
    for (int b = 0; b < 8; b++) begin
      if (base + 7 - b < NUM_VEC) begin
        r[b] = a[base + 7 - b];
      end
    end
    return r;
  endfunction

  always_comb begin
    porta_req_next = porta_req_reg;
    peri_req_next = peri_req_reg;
    portc_req_next = portc_req_reg;
    porta_enh_next = porta_enh_reg;
    porta_enl_next = porta_enl_reg;
    peri_enh_next = peri_enh_reg;
    peri_enl_next = peri_enl_reg;
    portc_enh_next = portc_enh_reg;
    portc_enl_next = portc_enl_reg;
    gie_next = gie_reg;
    edge_sel_next = edge_sel_reg;
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_PORTA_REQ: porta_req_next = reg_wdata;
        ADDR_PERI_REQ: peri_req_next = reg_wdata & PERI_WR_MASK;
        ADDR_PORTC_REQ: portc_req_next = reg_wdata[3:0];
        ADDR_PORTA_ENH: porta_enh_next = reg_wdata;
        ADDR_PORTA_ENL: porta_enl_next = reg_wdata;
        ADDR_PERI_ENH: peri_enh_next = reg_wdata;
        ADDR_PERI_ENL: peri_enl_next = reg_wdata;
        ADDR_PORTC_ENH: portc_enh_next = reg_wdata[3:0];
        ADDR_PORTC_ENL: portc_enl_next = reg_wdata[3:0];
        ADDR_EDGE_SEL: edge_sel_next = reg_wdata;
        ADDR_CTRL: gie_next = reg_wdata[CTRL_GIE];
        default: ;
      endcase
    end
    // Acknowledge clears, then new requests set: a set in the clear cycle wins
    peri_req_next = (peri_req_next & ~ack_bits(ack_clr, 0)) | peri_set;
    porta_req_next = (porta_req_next & ~ack_bits(ack_clr, 8)) | porta_set;
    portc_req_next = (portc_req_next & 4'(~ack_bits(ack_clr, 12))) | portc_set;
    rdata_next = RESET_BYTE;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_PORTA_REQ: rdata_next = porta_req_reg;
        ADDR_PERI_REQ: rdata_next = peri_req_reg;
        ADDR_PORTC_REQ: rdata_next = {4'h0, portc_req_reg};
        ADDR_PORTA_ENH: rdata_next = porta_enh_reg;
        ADDR_PORTA_ENL: rdata_next = porta_enl_reg;
        ADDR_PERI_ENH: rdata_next = peri_enh_reg;
        ADDR_PERI_ENL: rdata_next = peri_enl_reg;
        ADDR_PORTC_ENH: rdata_next = {4'h0, portc_enh_reg};
        ADDR_PORTC_ENL: rdata_next = {4'h0, portc_enl_reg};
        ADDR_EDGE_SEL: rdata_next = edge_sel_reg;
        ADDR_CTRL: rdata_next = {gie_reg, 7'h00};
        ADDR_VEC_ADDR: rdata_next = {3'h0, vec_reg};
        default: rdata_next = RESET_BYTE;
      endcase
    end
  end

  // ----------------------------------------
  // Priority selection
  // ----------------------------------------
  logic [NUM_VEC-1:0] pend_flat;
  logic [NUM_VEC-1:0][1:0] prio_flat;
  logic [1:0] best_prio;
  logic best_found;
  logic [VEC_W-1:0] best_vec;
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_flat
      // Priority per source from its high and low enable bits
      assign pend_flat[7-g] = peri_req_reg[g];
      assign prio_flat[7-g] = {peri_enh_reg[g], peri_enl_reg[g]};
      assign pend_flat[15-g] = porta_req_reg[g];
      assign prio_flat[15-g] = {porta_enh_reg[g], porta_enl_reg[g]};
      if (g < 4) begin : g_c
        assign pend_flat[19-g] = portc_req_reg[g];
        assign prio_flat[19-g] = {portc_enh_reg[g], portc_enl_reg[g]};
      end
    end
  endgenerate

  always_comb begin
    best_prio = PRIO_OFF;
    best_found = 1'b0;
    best_vec = '0;
    for (int v = 0; v < NUM_VEC; v++) begin
      // Strictly greater keeps the earliest vector on a tie
      if (pend_flat[v] && prio_flat[v] != PRIO_OFF && prio_flat[v] > best_prio) begin
        best_prio = prio_flat[v];
        best_found = 1'b1;
        best_vec = VEC_W'(v);
      end
    end
    irq_next = gie_reg && best_found && !(irq_ack && irq_reg);
    // Hold the offered vector steady until the core takes it
    vec_next = (irq_reg && !irq_ack) ? vec_reg : best_vec;
    // Core fetches high byte at the even address; the odd one follows
    fetch_next = VEC_TABLE_BASE + {10'h000, vec_next, 1'b0};
    wdt_rst_next = watchdog_timeout & watchdog_reset_select_option;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      porta_req_reg <= RESET_BYTE;
      peri_req_reg <= RESET_BYTE;
      portc_req_reg <= '0;
      porta_enh_reg <= RESET_BYTE;
      porta_enl_reg <= RESET_BYTE;
      peri_enh_reg <= RESET_BYTE;
      peri_enl_reg <= RESET_BYTE;
      portc_enh_reg <= '0;
      portc_enl_reg <= '0;
      edge_sel_reg <= RESET_BYTE;
      gie_reg <= 1'b0;
      rdata_reg <= RESET_BYTE;
      irq_reg <= 1'b0;
      vec_reg <= '0;
      wdt_rst_reg <= 1'b0;
      fetch_reg <= VEC_TABLE_BASE;
    end else begin
      porta_req_reg <= porta_req_next;
      peri_req_reg <= peri_req_next;
      portc_req_reg <= portc_req_next;
      porta_enh_reg <= porta_enh_next;
      porta_enl_reg <= porta_enl_next;
      peri_enh_reg <= peri_enh_next;
      peri_enl_reg <= peri_enl_next;
      portc_enh_reg <= portc_enh_next;
      portc_enl_reg <= portc_enl_next;
      edge_sel_reg <= edge_sel_next;
      gie_reg <= gie_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
      vec_reg <= vec_next;
      wdt_rst_reg <= wdt_rst_next;
      fetch_reg <= fetch_next;
    end
  end

  assign vec_fetch_addr = fetch_reg;
  assign irq_to_core = irq_reg;
  assign irq_vector = vec_reg;
  assign reg_rdata = rdata_reg;
  assign watchdog_sys_reset = wdt_rst_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_disabled_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !gie_reg |=> !irq_reg) else $error("Core interrupted while disabled");
  chk_pending_forward: assert property (@(posedge sys_clk) disable iff (!rst_n)
    gie_reg && best_found && !irq_reg |=> irq_reg) else $error("Request not forwarded");
  chk_wdt_request: assert property (@(posedge sys_clk) disable iff (!rst_n)
    watchdog_timeout && !watchdog_reset_select_option |=> peri_req_reg[PV_WDT])
    else $error("Watchdog request lost");
  chk_porta_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    porta_set[7] |=> porta_req_reg[7]) else $error("Port flag not set");
  chk_peri_reserved: assert property (@(posedge sys_clk) disable iff (!rst_n)
    peri_req_reg[2:1] == 2'b00) else $error("Reserved bits set");
  chk_ack_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    irq_reg && irq_ack && vec_reg == VEC_PORTA_BASE && !porta_set[7] && !reg_wr
    |=> !porta_req_reg[7])
    else $error("Pending bit kept after ack");
  chk_vec_stable: assert property (@(posedge sys_clk) disable iff (!rst_n)
    irq_reg && !irq_ack |=> $stable(vec_reg)) else $error("Vector changed before ack");
  chk_fetch_even: assert property (@(posedge sys_clk) disable iff (!rst_n)
    vec_fetch_addr[0] == 1'b0) else $error("Vector address odd");
  chk_prio_valid: assert property (@(posedge sys_clk) disable iff (!rst_n)
    irq_reg |-> prio_flat[vec_reg] != PRIO_OFF || $past(prio_flat[vec_reg]) != PRIO_OFF)
    else $error("Disabled source offered");
endmodule

// ---- sim/core_model.sv ----
// Core-side partner: takes vectored requests after a set delay and logs them.
// Assumes one clock and a controller that holds its request until acknowledged.
`timescale 1ns/1ps
module core_model
  import irq_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Handoff from the controller
  input wire logic irq_to_core,
  input wire logic [VEC_W-1:0] irq_vector,
  input wire logic [15:0] vec_fetch_addr,
  output logic irq_ack,
  // Control and log
  input wire logic [3:0] ack_delay,
  output logic [VEC_W-1:0] vec_log [8],
  output logic [15:0] addr_log [8],
  output int n_taken
);
  logic [3:0] wait_cnt;

  initial begin
    irq_ack = 1'b0;
    n_taken = 0;
    wait_cnt = 4'h0;
  end

  // Ack is one cycle wide, so a held request is never taken twice
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      irq_ack <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (irq_ack) begin
      irq_ack <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (irq_to_core && wait_cnt >= ack_delay) begin
      irq_ack <= 1'b1;
      vec_log[n_taken[2:0]] <= irq_vector;
      addr_log[n_taken[2:0]] <= vec_fetch_addr;
      n_taken <= n_taken + 1;
    end else if (irq_to_core) begin
      wait_cnt <= wait_cnt + 4'h1;
    end else begin
      wait_cnt <= 4'h0;
    end
  end
endmodule

// ---- sim/testbench.sv ----
// Self-checking bench for the vectored interrupt request controller.
// Assumes the core partner in core_model.sv and a 200 MHz clock.
`timescale 1ns/1ps
module testbench;
  import irq_ctrl_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] port_a_pin = '0;
  logic [3:0] port_c_pin = '0;
  logic comparator_request = 1'b0;
  logic [NUM_PERI_SRC-1:0] peri_request = '0;
  logic watchdog_timeout = 1'b0;
  logic watchdog_reset_select_option = 1'b0;
  logic irq_to_core;
  logic irq_ack;
  logic watchdog_sys_reset;
  logic [VEC_W-1:0] irq_vector;
  logic [15:0] vec_fetch_addr;
  logic [3:0] ack_delay = 4'h0;
  logic [VEC_W-1:0] vec_log [8];
  logic [15:0] addr_log [8];
  int n_taken;
  int n_fail = 0;
  int n_compared = 0;
  int n_sys_reset = 0;
  logic [7:0] enh_tab [3] = '{8'h01, 8'h81, 8'h80};
  logic [7:0] enl_tab [3] = '{8'h81, 8'h81, 8'h01};
  logic [VEC_W-1:0] first_tab [3] = '{5'h0F, 5'h08, 5'h08};

  always #2.5 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    if (watchdog_sys_reset === 1'b1) begin
      n_sys_reset++;
    end
  end

  vectored_irq_ctrl u_dut (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .port_a_pin(port_a_pin), .port_c_pin(port_c_pin),
    .comparator_request(comparator_request), .peri_request(peri_request),
    .watchdog_timeout(watchdog_timeout),
    .watchdog_reset_select_option(watchdog_reset_select_option),
    .irq_to_core(irq_to_core), .irq_vector(irq_vector), .vec_fetch_addr(vec_fetch_addr),
    .irq_ack(irq_ack), .watchdog_sys_reset(watchdog_sys_reset));

  core_model u_core (.sys_clk(sys_clk), .nrst(nrst), .irq_to_core(irq_to_core),
    .irq_vector(irq_vector), .vec_fetch_addr(vec_fetch_addr), .irq_ack(irq_ack),
    .ack_delay(ack_delay), .vec_log(vec_log), .addr_log(addr_log), .n_taken(n_taken));

  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic summarize();
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_check(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    check({8'h00, reg_rdata}, {8'h00, exp});
  endtask

  task automatic timeout_pulse();
    @(posedge sys_clk);
    watchdog_timeout <= 1'b1;
    @(posedge sys_clk);
    watchdog_timeout <= 1'b0;
    cycles(3);
  endtask

  task automatic expect_take(input int idx, input logic [VEC_W-1:0] v);
    int k;
    k = 0;
    while (n_taken <= idx && k < 100) begin
      @(posedge sys_clk);
      k++;
    end
    check({11'h000, vec_log[idx]}, {11'h000, v});
    check(addr_log[idx], VEC_TABLE_BASE + {10'h000, v, 1'b0});
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    cycles(16);
    nrst <= 1'b1;
    cycles(4);
    reg_check(ADDR_PORTA_REQ, 8'h00);
    reg_check(ADDR_PERI_REQ, 8'h00);
    reg_check(12'h0FD0, 8'h00);
    reg_write(ADDR_PORTA_REQ, 8'hA5);
    reg_check(ADDR_PORTA_REQ, 8'hA5);
    reg_write(ADDR_PERI_REQ, 8'hF9);
    reg_check(ADDR_PERI_REQ, 8'hF9);
    reg_write(ADDR_PERI_REQ, 8'h00);
    reg_write(ADDR_PORTA_REQ, 8'h00);
    port_a_pin <= 8'h20;
    cycles(8);
    reg_check(ADDR_PORTA_REQ, 8'h20);
    reg_write(ADDR_PORTA_REQ, 8'h00);
    reg_write(ADDR_EDGE_SEL, 8'h02);
    reg_check(ADDR_EDGE_SEL, 8'h02);
    port_a_pin <= 8'h22;
    cycles(8);
    reg_check(ADDR_PORTA_REQ, 8'h00);
    port_a_pin <= 8'h00;
    cycles(8);
    reg_check(ADDR_PORTA_REQ, 8'h02);
    reg_write(ADDR_PORTA_REQ, 8'h00);
    port_c_pin <= 4'h4;
    cycles(8);
    reg_check(ADDR_PORTC_REQ, 8'h04);
    reg_write(ADDR_PORTC_REQ, 8'h00);
    port_c_pin <= 4'h0;
    cycles(8);
    reg_check(ADDR_PORTC_REQ, 8'h04);
    reg_write(ADDR_PORTC_REQ, 8'h00);
    @(posedge sys_clk);
    comparator_request <= 1'b1;
    peri_request <= 8'h1F;
    @(posedge sys_clk);
    comparator_request <= 1'b0;
    peri_request <= 8'h00;
    cycles(2);
    reg_check(ADDR_PORTA_REQ, 8'h40);
    reg_check(ADDR_PERI_REQ, 8'h19);
    reg_write(ADDR_PERI_REQ, 8'h00);
    reg_write(ADDR_PORTA_REQ, 8'h00);
    timeout_pulse();
    reg_check(ADDR_PERI_REQ, 8'h80);
    check(16'(n_sys_reset), 16'h0000);
    reg_write(ADDR_PERI_REQ, 8'h00);
    watchdog_reset_select_option <= 1'b1;
    timeout_pulse();
    reg_check(ADDR_PERI_REQ, 8'h00);
    check(16'(n_sys_reset), 16'h0001);
    watchdog_reset_select_option <= 1'b0;
    // Pending but globally disabled: only polling sees them
    reg_write(ADDR_PORTA_ENH, 8'h01);
    reg_write(ADDR_PORTA_ENL, 8'h81);
    reg_write(ADDR_PORTA_REQ, 8'h81);
    reg_check(ADDR_PORTA_ENL, 8'h81);
    cycles(5);
    check({15'h0000, irq_to_core}, 16'h0000);
    reg_check(ADDR_PORTA_REQ, 8'h81);
    for (int i = 0; i < 3; i++) begin
      reg_write(ADDR_CTRL, 8'h00);
      reg_write(ADDR_PORTA_ENH, enh_tab[i]);
      reg_write(ADDR_PORTA_ENL, enl_tab[i]);
      reg_write(ADDR_PORTA_REQ, 8'h81);
      ack_delay <= 4'(i * 3);
      reg_write(ADDR_CTRL, 8'h80);
      expect_take(2 * i, first_tab[i]);
      expect_take(2 * i + 1, first_tab[i] ^ 5'h07);
      cycles(2);
      reg_check(ADDR_PORTA_REQ, 8'h00);
    end
    // Watchdog slot and a both-edge port C pin taken as vectors
    reg_write(ADDR_PERI_ENH, 8'h80);
    reg_write(ADDR_PERI_ENL, 8'h80);
    timeout_pulse();
    expect_take(6, 5'h00);
    reg_write(ADDR_PORTC_ENL, 8'h04);
    port_c_pin <= 4'h4;
    expect_take(7, 5'h11);
    reg_write(ADDR_CTRL, 8'h00);
    reg_write(ADDR_PORTA_ENH, 8'h00);
    reg_write(ADDR_PORTA_ENL, 8'h00);
    reg_write(ADDR_PORTA_REQ, 8'h81);
    reg_write(ADDR_CTRL, 8'h80);
    cycles(6);
    check({15'h0000, irq_to_core}, 16'h0000);
    check(16'(n_taken), 16'h0008);
    summarize();
  end

  // Whole run needs well under 2000 cycles
  initial begin
    #(20000 * 5);
    n_fail++;
    summarize();
  end
endmodule
